// >>> shared/sfw_pkg.sv
package sfw_pkg;

    // clock and timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int RESET_PULSE_NS = 500;
    // least time, rounded up to whole cycles
    localparam int RESET_PULSE_CYCLES = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PULSE_W = 6;
    localparam int PRESCALE_CYCLES = 65536;
    localparam int WAKE_DELAY_CYCLES = 514;
    localparam int WAKE_W = 10;

    // register map (byte addresses)
    localparam logic [31:0] OFS_CTRL = 32'h0000_0000;
    localparam logic [31:0] OFS_STATUS = 32'h0000_0004;

    // watchdog_control layout
    localparam int CNT_W = 7;
    localparam int ACT_BIT = 7;
    localparam int TOP_BIT = 6;
    localparam logic [7:0] CTRL_RESET = 8'h7f;
    localparam logic [CNT_W-1:0] CNT_EXPIRE = 7'h40;

    // status layout
    localparam int ST_FAULT_BIT = 0;
    localparam int ST_HW_BIT = 1;
    localparam int ST_HALT_BIT = 2;
    localparam int ST_WAKE_BIT = 3;
    localparam int ST_PULSE_BIT = 4;
    localparam int ST_WAIT_BIT = 5;
    localparam int ST_USED_W = 6;

    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        ST_RUN = 3'h1,
        ST_HALT = 3'h2,
        ST_WAKE = 3'h4
    } sfw_state_e;

endpackage : sfw_pkg

// >>> shared/sfw_tick_if.sv
`timescale 1ns/10ps
interface sfw_tick_if;
    logic run;
    logic clr;
    logic tick;

    modport ctl (output run, output clr, input tick);
    modport pre (input run, input clr, output tick);
endinterface : sfw_tick_if

// >>> core/sfw_prescaler.sv
`timescale 1ns/10ps
module sfw_prescaler
    import sfw_pkg::*;
#(
    parameter int CYCLES = PRESCALE_CYCLES
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // control and tick
    sfw_tick_if.pre bus
);

    localparam int W = $clog2(CYCLES);
    localparam logic [W-1:0] LAST = W'(CYCLES - 1);

    typedef struct packed {
        logic [W-1:0] cnt;
        logic tick;
    } sfw_pre_s;

    sfw_pre_s r_reg;
    sfw_pre_s r_next;

    always_comb begin
        r_next = r_reg;
        r_next.tick = 1'b0;
        if (bus.clr) begin
            r_next.cnt = '0;
        end else if (bus.run) begin
            if (r_reg.cnt == LAST) begin
                r_next.cnt = '0;
                r_next.tick = 1'b1; // [RULE_01]
            end else begin
                r_next.cnt = r_reg.cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign bus.tick = r_reg.tick;

endmodule : sfw_prescaler

// >>> core/sfw_watchdog.sv
// Behaviour
// [RULE_01] The 7-bit countdown in the control register drops by one every 65,536 cycles.
// [RULE_02] When armed and the countdown passes 40h to 3Fh a reset pulse of about 500 ns starts.
// [RULE_03] The countdown runs all the time, armed or not; only the reset depends on arming. Here it stops in halt and during the wake delay.
// [RULE_04] Software must rewrite the control register before the countdown top bit clears.
// [RULE_05] Software writes values C0h to FFh: armed, top bit set, six low bits the delay.
// [RULE_06] In software mode the watchdog is disarmed after reset and stays armed once armed.
// [RULE_07] Only software sets the activation bit and only reset clears it; writing 0 is ignored.
// [RULE_08] Writing the activation bit set with the top bit clear forces an immediate reset.
// [RULE_09] In hardware mode the watchdog is always armed and the activation bit is ignored.
// [RULE_10] In halt the counter stops and no reset is made until a wake interrupt or reset.
// [RULE_11] After a wake interrupt the counter resumes only after 514 clock cycles.
// [RULE_12] Reset loads the control register with 7Fh: bit 7 activation, bits 6 to 0 count.
// [RULE_13] Software should refresh the watchdog before entering halt.
// [RULE_14] In wait mode the watchdog counts and resets exactly as in run mode.
//
// Our own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module sfw_watchdog
    import sfw_pkg::*;
#(
    parameter int PRESCALE = PRESCALE_CYCLES,
    parameter int ADDR_W = 4
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    // axi4-lite write data
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // axi4-lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read address
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    // axi4-lite read data
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // option strap and power modes
    input wire logic hw_option_strap,
    input wire logic halt_req,
    input wire logic wait_req,
    input wire logic ext_wake,
    // open-drain chip reset pin
    output logic rst_pin_o,
    output logic rst_pin_oe
);

    localparam logic [WAKE_W-1:0] WAKE_LAST = WAKE_W'(WAKE_DELAY_CYCLES - 1);
    localparam logic [PULSE_W-1:0] PULSE_LAST = PULSE_W'(RESET_PULSE_CYCLES - 1);
    localparam logic [ADDR_W-1:0] A_CTRL = OFS_CTRL[ADDR_W-1:0];
    localparam logic [ADDR_W-1:0] A_STATUS = OFS_STATUS[ADDR_W-1:0];

    typedef struct packed {
        sfw_state_e state;
        logic [WAKE_W-1:0] wake_cnt;
        logic activation;
        logic [CNT_W-1:0] count;
        logic hw_mode;
        logic strap_taken;
        logic [PULSE_W-1:0] pulse_cnt;
        logic pin_oe;
        logic fault_flag;
        logic wait_seen;
        logic awready;
        logic wready;
        logic aw_held;
        logic w_held;
        logic [ADDR_W-1:0] waddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } sfw_core_s;

    localparam sfw_core_s CORE_RESET = '{
        state: ST_RUN,
        wake_cnt: '0,
        activation: CTRL_RESET[ACT_BIT],
        count: CTRL_RESET[CNT_W-1:0],
        hw_mode: 1'b0,
        strap_taken: 1'b0,
        pulse_cnt: '0,
        pin_oe: 1'b0,
        fault_flag: 1'b0,
        wait_seen: 1'b0,
        awready: 1'b1,
        wready: 1'b1,
        aw_held: 1'b0,
        w_held: 1'b0,
        waddr: '0,
        wdata: '0,
        wstrb: '0,
        bvalid: 1'b0,
        bresp: RESP_OKAY,
        arready: 1'b1,
        rvalid: 1'b0,
        rresp: RESP_OKAY,
        rdata: '0
    };

    sfw_core_s r_reg;
    sfw_core_s r_next;

    sfw_tick_if tick_bus ();

    sfw_prescaler #(
        .CYCLES(PRESCALE)
    ) u_prescaler (
        .aclk(aclk),
        .aresetn(aresetn),
        .bus(tick_bus.pre)
    );

    // prescaler only runs in run mode; wait mode does not stop it
    assign tick_bus.run = (r_reg.state == ST_RUN); // [RULE_10] [RULE_14]
    // cleared while halted so the restart after wake begins a full period
    assign tick_bus.clr = (r_reg.state != ST_RUN);

    logic armed;
    logic fire;
    logic wr_go;
    logic [31:0] rd_word;
    logic rd_err;
    logic [ST_USED_W-1:0] status_bits;

    always_comb begin
        status_bits = '0;
        status_bits[ST_FAULT_BIT] = r_reg.fault_flag;
        status_bits[ST_HW_BIT] = r_reg.hw_mode;
        status_bits[ST_HALT_BIT] = (r_reg.state == ST_HALT);
        status_bits[ST_WAKE_BIT] = (r_reg.state == ST_WAKE);
        status_bits[ST_PULSE_BIT] = r_reg.pin_oe;
        status_bits[ST_WAIT_BIT] = r_reg.wait_seen;
    end

    always_comb begin
        rd_word = '0;
        rd_err = 1'b0;
        if (araddr == A_CTRL) begin
            rd_word[ACT_BIT] = r_reg.activation;
            rd_word[CNT_W-1:0] = r_reg.count;
        end else if (araddr == A_STATUS) begin
            rd_word[ST_USED_W-1:0] = status_bits;
        end else begin
            rd_err = 1'b1;
        end
    end

    always_comb begin
        r_next = r_reg;
        fire = 1'b0;
        armed = r_reg.hw_mode | r_reg.activation; // [RULE_09]
        wr_go = r_reg.aw_held & r_reg.w_held & ~r_reg.bvalid;
        r_next.wait_seen = wait_req;

        // option strap caught once, just after reset release
        if (!r_reg.strap_taken) begin
            r_next.strap_taken = 1'b1;
            r_next.hw_mode = hw_option_strap; // [RULE_09]
        end

        // power-mode sequencing
        unique case (r_reg.state)
            ST_RUN: begin
                if (halt_req) begin
                    r_next.state = ST_HALT; // [RULE_10]
                end
            end
            ST_HALT: begin
                if (ext_wake) begin
                    r_next.state = ST_WAKE;
                    r_next.wake_cnt = '0;
                end
            end
            ST_WAKE: begin
                if (r_reg.wake_cnt == WAKE_LAST) begin
                    r_next.state = ST_RUN; // [RULE_11]
                end else begin
                    r_next.wake_cnt = r_reg.wake_cnt + 1'b1;
                end
            end
            default: begin
                r_next.state = ST_RUN;
            end
        endcase

        // countdown runs armed or not, in run mode only, wraps 00h to 7Fh
        if (tick_bus.tick && r_reg.state == ST_RUN) begin
            r_next.count = r_reg.count - 1'b1; // [RULE_01] [RULE_03]
            if (armed && r_reg.count == CNT_EXPIRE) begin
                fire = 1'b1; // [RULE_02]
            end
        end

        // axi write channels, taken in either order
        if (awvalid && r_reg.awready) begin
            r_next.aw_held = 1'b1;
            r_next.awready = 1'b0;
            r_next.waddr = awaddr;
        end
        if (wvalid && r_reg.wready) begin
            r_next.w_held = 1'b1;
            r_next.wready = 1'b0;
            r_next.wdata = wdata;
            r_next.wstrb = wstrb;
        end
        if (r_reg.bvalid && bready) begin
            r_next.bvalid = 1'b0;
            r_next.aw_held = 1'b0;
            r_next.w_held = 1'b0;
            r_next.awready = 1'b1;
            r_next.wready = 1'b1;
        end

        // software write sets the count over a same-cycle tick; an expiry fire from that tick still stands
        if (wr_go) begin
            r_next.bvalid = 1'b1;
            r_next.bresp = RESP_OKAY;
            if (r_reg.waddr == A_CTRL) begin
                if (r_reg.wstrb[0]) begin
                    r_next.count = r_reg.wdata[CNT_W-1:0];
                    if (r_reg.wdata[ACT_BIT]) begin
                        r_next.activation = 1'b1; // [RULE_06] [RULE_07]
                    end
                    if ((r_reg.wdata[ACT_BIT] || armed) && !r_reg.wdata[TOP_BIT]) begin
                        fire = 1'b1; // [RULE_08]
                    end
                end
            end else if (r_reg.waddr == A_STATUS) begin
                if (r_reg.wstrb[0] && r_reg.wdata[ST_FAULT_BIT]) begin
                    r_next.fault_flag = 1'b0;
                end
            end else begin
                r_next.bresp = RESP_SLVERR;
            end
        end

        // fault flag: a new event beats a same-cycle clear
        if (fire) begin
            r_next.fault_flag = 1'b1;
        end

        // reset pulse; triggers during a running pulse merge into it
        if (r_reg.pin_oe) begin
            if (r_reg.pulse_cnt == PULSE_LAST) begin
                r_next.pin_oe = 1'b0;
            end else begin
                r_next.pulse_cnt = r_reg.pulse_cnt + 1'b1;
            end
        end else if (fire) begin
            r_next.pin_oe = 1'b1; // [RULE_02]
            r_next.pulse_cnt = '0;
        end

        // axi read channels
        if (arvalid && r_reg.arready) begin
            r_next.arready = 1'b0;
            r_next.rvalid = 1'b1;
            r_next.rdata = rd_word;
            r_next.rresp = rd_err ? RESP_SLVERR : RESP_OKAY;
        end
        if (r_reg.rvalid && rready) begin
            r_next.rvalid = 1'b0;
            r_next.arready = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r_reg <= CORE_RESET; // [RULE_12] [RULE_06]
        end else begin
            r_reg <= r_next;
        end
    end

    assign awready = r_reg.awready;
    assign wready = r_reg.wready;
    assign bvalid = r_reg.bvalid;
    assign bresp = r_reg.bresp;
    assign arready = r_reg.arready;
    assign rvalid = r_reg.rvalid;
    assign rresp = r_reg.rresp;
    assign rdata = r_reg.rdata;
    // open drain: only ever pulls low
    assign rst_pin_o = 1'b0;
    assign rst_pin_oe = r_reg.pin_oe;

endmodule : sfw_watchdog

// >>> tb/sfw_watchdog_checker.sv
`timescale 1ns/10ps
module sfw_watchdog_checker
    import sfw_pkg::*;
#(
    parameter int PRESCALE = PRESCALE_CYCLES,
    parameter int ADDR_W = 4
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // register bus
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic rvalid,
    input wire logic rready,
    // reset pin
    input wire logic rst_pin_o,
    input wire logic rst_pin_oe
);
    logic [PULSE_W-1:0] hi_cnt_reg;

    // length of the current pulse, wraps if it overstays
    always_ff @(posedge aclk) begin
        if (!aresetn || !rst_pin_oe) hi_cnt_reg <= '0;
        else hi_cnt_reg <= hi_cnt_reg + 1'b1;
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_PULSE_LEN: assert property (
        $fell(rst_pin_oe) |-> hi_cnt_reg == PULSE_W'(RESET_PULSE_CYCLES)) else $error("pulse len");
    AST_PIN_LEVEL: assert property (
        rst_pin_oe |-> rst_pin_o == 1'b0) else $error("pin level");
    AST_RST_STATE: assert property (
        $rose(aresetn) |-> !rst_pin_oe && awready && arready && !bvalid && !rvalid)
        else $error("reset state");
    AST_FORCE: assert property (
        awvalid && awready && wvalid && wready && awaddr == OFS_CTRL[ADDR_W-1:0] && wstrb[0]
        && wdata[ACT_BIT] && !wdata[TOP_BIT] && !rst_pin_oe |-> ##[1:3] rst_pin_oe)
        else $error("forced reset");
    AST_B_HOLD: assert property (
        bvalid && !bready |=> bvalid && $stable(bresp)) else $error("bresp hold");
    AST_R_HOLD: assert property (
        rvalid && !rready |=> rvalid && $stable(rdata)) else $error("rdata hold");
    AST_R_ANSWER: assert property (
        arvalid && arready |=> rvalid) else $error("read answer");
    AST_B_ANSWER: assert property (
        awvalid && awready && wvalid && wready |-> ##[1:2] bvalid) else $error("write answer");
endmodule : sfw_watchdog_checker

bind sfw_watchdog sfw_watchdog_checker #(.PRESCALE(PRESCALE), .ADDR_W(ADDR_W)) chk_inst (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
    .bvalid, .bready, .arvalid, .arready, .rdata, .rvalid, .rready, .rst_pin_o, .rst_pin_oe);

// >>> tb/sfw_watchdog_tb_top.sv
`timescale 1ns/10ps
module sfw_watchdog_tb_top;
    import sfw_pkg::*;
    localparam int PS = 8;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, oe_q;
    logic awready, wready, bvalid, arready, rvalid, rst_pin_o, rst_pin_oe;
    logic hw_option_strap, halt_req, wait_req, ext_wake;
    logic [3:0] awaddr, araddr, wstrb;
    logic [2:0] awprot, arprot;
    logic [31:0] wdata, rdata, rd_v;
    logic [1:0] bresp, rresp, resp;
    int err_total, checks, cyc, rises, t, d, n0;

    sfw_watchdog #(.PRESCALE(PS)) sfw_watchdog_inst (.aclk, .aresetn, .awaddr, .awprot,
        .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
        .araddr, .arprot, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .hw_option_strap, .halt_req, .wait_req, .ext_wake, .rst_pin_o, .rst_pin_oe);

    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    always @(posedge aclk) begin
        cyc++;
        oe_q <= rst_pin_oe;
        if (rst_pin_oe && !oe_q) rises++;
        if (cyc == 20000) begin
            err_total++;
            results();
        end
    end

    task automatic results();
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : results

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic wr(input logic [7:0] v);
        awaddr <= OFS_CTRL[3:0];
        wdata <= {24'h0, v};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (awvalid || wvalid);
        do @(posedge aclk); while (!bvalid);
        resp = bresp;
        bready <= 1'b0;
        @(posedge aclk);
    endtask : wr

    task automatic rd(input logic [3:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        rd_v = rdata;
        resp = rresp;
        rready <= 1'b0;
        @(posedge aclk);
    endtask : rd

    task automatic rst(input logic hw);
        aresetn <= 1'b0;
        hw_option_strap <= hw;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
    endtask : rst

    // counts edges until the pin is pulled
    task automatic wait_oe(input int lim);
        t = 0;
        while (rst_pin_oe !== 1'b1 && t < lim) begin
            @(posedge aclk);
            t++;
        end
    endtask : wait_oe

    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {hw_option_strap, halt_req, wait_req, ext_wake} = '0;
        {awaddr, araddr, awprot, arprot, wdata} = '0;
        wstrb = 4'hf;
        void'($urandom(32'h030c));
        rst(1'b0);
        rd(OFS_CTRL[3:0]);
        chk("ctrl_reset", 32'(CTRL_RESET), rd_v);
        rd(4'h8);
        chk("unmapped", 32'(RESP_SLVERR), 32'(resp));
        wr(8'h7f);
        chk("wr_resp", 32'(RESP_OKAY), 32'(resp));
        repeat (10 * PS) @(posedge aclk);
        rd(OFS_CTRL[3:0]);
        chk("count_run", 32'h1, 32'(rd_v[6:0] inside {[7'h73:7'h76]}));
        t = rises;
        repeat (60 * PS) @(posedge aclk);
        chk("unarmed_quiet", 32'(t), 32'(rises));
        wr(8'hff);
        wr(8'h7f);
        rd(OFS_CTRL[3:0]);
        chk("act_sticky", 32'h1, 32'(rd_v[ACT_BIT]));
        t = rises;
        // shortest reload still outlasts the gap
        repeat (20) begin
            wait_req <= 1'($urandom_range(0, 1));
            wr(8'(8'hc8 + $urandom_range(0, 55)));
            repeat ($urandom_range(5, 50)) @(posedge aclk);
        end
        chk("refresh_quiet", 32'(t), 32'(rises));
        d = $urandom_range(0, 5);
        wr(8'(8'hc0 + d));
        wait_oe(200);
        chk("expire_time", 32'h1, 32'(t + 4 >= 8 * d && t <= 8 * d + 9));
        n0 = 0;
        while (rst_pin_oe === 1'b1 && n0 < 100) begin
            @(posedge aclk);
            n0++;
        end
        chk("pulse_len", 32'(RESET_PULSE_CYCLES), 32'(n0));
        rd(OFS_STATUS[3:0]);
        chk("fault_flag", 32'h1, 32'(rd_v[ST_FAULT_BIT]));
        chk("pulse_off", 32'h0, 32'(rd_v[ST_PULSE_BIT]));
        wr(8'h80);
        chk("forced", 32'h1, 32'(rst_pin_oe));
        rst(1'b0);
        wr(8'hc8);
        halt_req <= 1'b1;
        @(posedge aclk);
        halt_req <= 1'b0;
        @(posedge aclk);
        rd(OFS_CTRL[3:0]);
        n0 = int'(rd_v);
        t = rises;
        repeat (200) @(posedge aclk);
        ext_wake <= 1'b1;
        @(posedge aclk);
        ext_wake <= 1'b0;
        repeat (450) @(posedge aclk);
        rd(OFS_CTRL[3:0]);
        chk("halt_frozen", 32'(n0), rd_v);
        chk("halt_quiet", 32'(t), 32'(rises));
        repeat (100) @(posedge aclk);
        rd(OFS_CTRL[3:0]);
        chk("wake_resume", 32'h1, 32'(rd_v[6:0] < 7'(n0)));
        rst(1'b1);
        wait_oe(700);
        chk("hw_expire", 32'h1, 32'(t >= 64 * PS - 16 && t <= 64 * PS + 8));
        results();
    end
endmodule : sfw_watchdog_tb_top
